// file: sim/serial_channel_properties.sv
// checker of the serial channel top-level ports
`timescale 1ns/1ps
`default_nettype none
module serial_channel_properties (
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic HREADY_IN,
  input wire logic [31:0] HRDATA_OUT,
  input wire logic HREADYOUT_OUT,
  input wire logic HRESP_OUT,
  input wire logic SOUT_OUT,
  input wire logic SOUT_OE_OUT,
  input wire logic SCLK_OUT,
  input wire logic SCLK_OE_OUT,
  input wire logic SRDY_OUT,
  input wire logic SRDY_OE_OUT,
  input wire logic SERIAL_PINS_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  logic acc;
  assign acc = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
  property p_bus; HREADYOUT_OUT && !HRESP_OUT; endproperty
  a_bus: assert property (p_bus) else $error("bus stall or error");
  property p_upper; HRDATA_OUT[31:8] == 24'h000000; endproperty
  a_upper: assert property (p_upper) else $error("read data above byte");
  property p_idle; !$past(acc) |-> HRDATA_OUT == 32'h00000000; endproperty
  a_idle: assert property (p_idle) else $error("read data without read");
  property p_unmap; acc && !HWRITE_IN && HADDR_IN[17:2] > 16'hFF4F |=> HRDATA_OUT == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_rst; $fell(RESET_IN) |-> SOUT_OUT && SCLK_OUT && SRDY_OUT && !SERIAL_PINS_OUT; endproperty
  a_rst: assert property (p_rst) else $error("pins not idle after reset");
  property p_pins; !SERIAL_PINS_OUT |-> !(SOUT_OE_OUT || SCLK_OE_OUT || SRDY_OE_OUT); endproperty
  a_pins: assert property (p_pins) else $error("pin driven as port");
  property p_oe; SCLK_OE_OUT |-> !SRDY_OE_OUT; endproperty
  a_oe: assert property (p_oe) else $error("master and slave pins both on");
  // fastest divider tick is four clocks, so a divider-timed bit lasts at least eight
  property p_bit; $fell(SOUT_OUT) |-> !SOUT_OUT [*8]; endproperty
  a_bit: assert property (p_bit) else $error("serial bit too short");
  property p_sclk; $fell(SCLK_OUT) |-> !SCLK_OUT [*4]; endproperty
  a_sclk: assert property (p_sclk) else $error("shift clock half period short");
endmodule : serial_channel_properties
`default_nettype wire

// file: sim/serial_peer.sv
// far-side serial device: frame sender and async or clocked receiver
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(parameter int BIT = 8) (
  input wire logic clk,
  input wire logic sout,
  input wire logic sclk,
  output logic sin
);
  logic [7:0] got;
  initial sin = 1'b1;
  // sample at mid-bit, lsb first
  task automatic rx_async();
    @(negedge sout);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      got = {sout, got[7:1]};
    end
  endtask : rx_async
  task automatic rx_sync();
    repeat (8) begin
      @(posedge sclk);
      got = {got[6:0], sout};
    end
  endtask : rx_sync
  // stop level chosen by caller, so a bad stop can be sent
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      sin <= f[i];
      repeat (BIT) @(posedge clk);
    end
    sin <= 1'b1;
  endtask : send
endmodule : serial_peer
`default_nettype wire

// file: sim/tb.sv
// testbench of the serial channel
`timescale 1ns/1ps
`default_nettype none
`include "serial_channel_defines.svh"
module tb;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, tick = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, seed = 32'h141A4;
  logic hrdy, hresp, sin, sout, sout_oe, sclk, sclk_oe, srdy, srdy_oe, pins;
  logic [7:0] mq[$];
  int n_errors = 0, compares = 0, cyc = 0;
  serial_channel_control dut (.CLK_IN(clk), .RESET_IN(rst), .HSEL_IN(hsel),
    .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
    .HWDATA_IN(hwdata), .HREADY_IN(hrdy), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hrdy),
    .HRESP_OUT(hresp), .TIMER7_TICK_IN(tick), .SIN_IN(sin), .SOUT_OUT(sout),
    .SOUT_OE_OUT(sout_oe), .SCLK_IN(1'b1), .SCLK_OUT(sclk), .SCLK_OE_OUT(sclk_oe),
    .SRDY_OUT(srdy), .SRDY_OE_OUT(srdy_oe), .SERIAL_PINS_OUT(pins));
  serial_peer peer (.clk(clk), .sout(sout), .sclk(sclk), .sin(sin));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    tick <= (cyc % 16 == 0);
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      end_sim();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {14'h0, idx, 2'h0};
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask : rdc
  task automatic poll(input int b);
    rd = 32'hFFFFFFFF;
    for (int i = 0; i < 300 && rd[b] !== 1'b0; i++) bus(1'b0, `IDX_CONTROL, 32'h0);
  endtask : poll
  task automatic end_sim();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) rdc(`IDX_CONFIG + 16'(i), 32'h0);
    $display("reset values done");
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      bus(1'b1, `IDX_CONFIG, {24'h0, seed[7:5], 4'(i), seed[0]});
      rdc(`IDX_CONFIG, {24'h0, seed[7:5], 4'(i), seed[0]});
    end
    bus(1'b1, `IDX_CONTROL, 32'h02);
    rdc(`IDX_CONTROL, 32'h0);
    $display("readback done");
    bus(1'b1, `IDX_CONFIG, 32'h17);
    mq.push_back(seed[15:8]);
    bus(1'b1, `IDX_TX_BUF, {24'h0, seed[15:8]});
    rdc(`IDX_TX_BUF, {24'h0, seed[15:8]});
    bus(1'b1, `IDX_CONTROL, 32'h01);
    fork peer.rx_async(); join_none
    bus(1'b1, `IDX_CONTROL, 32'h03);
    rdc(`IDX_CONTROL, 32'h03);
    poll(1);
    chk({24'h0, peer.got}, {24'h0, mq.pop_front()});
    $display("async transmit done");
    bus(1'b1, `IDX_CONFIG, 32'h11);
    mq.push_back(seed[23:16]);
    bus(1'b1, `IDX_TX_BUF, {24'h0, seed[23:16]});
    bus(1'b1, `IDX_CONTROL, 32'h81);
    fork peer.rx_sync(); join_none
    bus(1'b1, `IDX_CONTROL, 32'h83);
    poll(1);
    chk({24'h0, peer.got}, {24'h0, mq.pop_front()});
    $display("clocked transmit done");
    bus(1'b1, `IDX_CONFIG, 32'h17);
    bus(1'b1, `IDX_CONTROL, 32'h0C);
    peer.send(seed[31:24], 1'b1);
    poll(3);
    rdc(`IDX_RX_BUF, {24'h0, seed[31:24]});
    rdc(`IDX_CONTROL, 32'h04);
    // bad stop, no rearm
    peer.send(~seed[31:24], 1'b0);
    repeat (20) @(posedge clk);
    rdc(`IDX_CONTROL, 32'h54);
    bus(1'b1, `IDX_CONTROL, 32'h14);
    rdc(`IDX_CONTROL, 32'h44);
    bus(1'b1, `IDX_CONTROL, 32'h00);
    rdc(`IDX_CONTROL, 32'h00);
    $display("receive done");
    end_sim();
  end
endmodule : tb
bind serial_channel_control serial_channel_properties chk (.CLK_IN(CLK_IN),
  .RESET_IN(RESET_IN), .HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN),
  .HWRITE_IN(HWRITE_IN), .HREADY_IN(HREADY_IN), .HRDATA_OUT(HRDATA_OUT),
  .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT), .SOUT_OUT(SOUT_OUT),
  .SOUT_OE_OUT(SOUT_OE_OUT), .SCLK_OUT(SCLK_OUT), .SCLK_OE_OUT(SCLK_OE_OUT),
  .SRDY_OUT(SRDY_OUT), .SRDY_OE_OUT(SRDY_OE_OUT), .SERIAL_PINS_OUT(SERIAL_PINS_OUT));
`default_nettype wire

// file: verilog/serial_channel_control.sv
// serial channel: AHB-Lite register set, transmit/receive engine and pin takeover
`timescale 1ns/1ps
`default_nettype none
`include "serial_channel_defines.svh"
module serial_channel_control (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  // AHB-Lite slave
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  // timer seven underflow pulse
  input wire logic TIMER7_TICK_IN,
  // serial pins
  input wire logic SIN_IN,
  output logic SOUT_OUT,
  output logic SOUT_OE_OUT,
  input wire logic SCLK_IN,
  output logic SCLK_OUT,
  output logic SCLK_OE_OUT,
  output logic SRDY_OUT,
  output logic SRDY_OE_OUT,
  output logic SERIAL_PINS_OUT
);
  shift_clock_if sc ();

  // bus state
  logic wr_pend_r, wr_pend_nxt;
  logic [1:0] wr_sel_r, wr_sel_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic hit;
  logic [1:0] sel;
  logic accept;
  logic [7:0] wdata;
  logic cfg_wr, ctl_wr, txb_wr;

  // register state
  logic pin_en_r, pin_en_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic [1:0] clk_src_r, clk_src_nxt;
  logic par_odd_r, par_odd_nxt;
  logic par_en_r, par_en_nxt;
  logic stop2_r, stop2_nxt;
  logic msb_r, msb_nxt;
  logic fer_r, fer_nxt;
  logic per_r, per_nxt;
  logic oer_r, oer_nxt;
  logic rx_trig_r, rx_trig_nxt;
  logic rx_en_r, rx_en_nxt;
  logic tx_trig_r, tx_trig_nxt;
  logic tx_en_r, tx_en_nxt;
  logic [7:0] tx_data_r, tx_data_nxt;
  logic [7:0] rx_data_r, rx_data_nxt;
  logic tx_go, rx_go;

  // engine state
  serial_channel_pkg::tx_state_t tx_state_r, tx_state_nxt;
  serial_channel_pkg::rx_state_t rx_state_r, rx_state_nxt;
  logic [3:0] tx_cnt_r, tx_cnt_nxt;
  logic [3:0] rx_cnt_r, rx_cnt_nxt;
  logic tx_half_r, tx_half_nxt;
  logic rx_half_r, rx_half_nxt;
  logic [7:0] tx_hold_r, tx_hold_nxt;
  logic [7:0] rx_shift_r, rx_shift_nxt;
  logic sout_r, sout_nxt;
  logic srdy_r, srdy_nxt;
  logic sync_tx_r, sync_tx_nxt;
  logic sync_rx_r, sync_rx_nxt;
  logic rx_per_r, rx_per_nxt;
  logic tx_done_r, tx_done_nxt;
  logic rx_done_r, rx_done_nxt;
  logic fer_ev_r, fer_ev_nxt;
  logic per_ev_r, per_ev_nxt;
  logic is_async;
  logic [3:0] nbits;
  logic tx_adv;
  logic rx_smp;
  logic sin_eff;

  // pin output state
  logic sout_pin_r, sout_pin_nxt;
  logic sout_oe_r, sout_oe_nxt;
  logic sclk_pin_r, sclk_pin_nxt;
  logic sclk_oe_r, sclk_oe_nxt;
  logic srdy_pin_r, srdy_pin_nxt;
  logic srdy_oe_r, srdy_oe_nxt;
  logic pins_r, pins_nxt;

  function automatic logic [2:0] bit_pos(input logic [3:0] idx, input logic [3:0] nb,
                                         input logic msb);
    logic [3:0] p;
    p = msb ? (nb - 4'h1 - idx) : idx;
    return p[2:0];
  endfunction : bit_pos

  function automatic logic parity_bit(input logic [7:0] d, input logic [3:0] nb,
                                      input logic odd);
    logic ones;
    ones = ^(d & ((nb == `BITS7) ? `MASK7 : `MASK8));
    return odd ? ~ones : ones;
  endfunction : parity_bit

  shift_clock_gen u_clock (
    .clk(CLK_IN),
    .rst(RESET_IN),
    .sc(sc.gen)
  );

  assign sc.mode = mode_r;
  assign sc.clk_src = clk_src_r;
  assign sc.active = (tx_state_r == serial_channel_pkg::TX_DATA) && !is_async;
  assign sc.timer_tick = TIMER7_TICK_IN;
  assign sc.ext_sclk = pin_en_r ? SCLK_IN : 1'b1;

  // bus: address phase decode, write applied in the data phase
  always_comb begin
    hit = 1'b0;
    sel = `SEL_CONFIG;
    if (HADDR_IN[31:18] != 14'h0000) begin
      hit = 1'b0;
    end else if (HADDR_IN[17:2] == `IDX_CONFIG) begin
      hit = 1'b1;
      sel = `SEL_CONFIG;
    end else if (HADDR_IN[17:2] == `IDX_CONTROL) begin
      hit = 1'b1;
      sel = `SEL_CONTROL;
    end else if (HADDR_IN[17:2] == `IDX_TX_BUF) begin
      hit = 1'b1;
      sel = `SEL_TX_BUF;
    end else if (HADDR_IN[17:2] == `IDX_RX_BUF) begin
      hit = 1'b1;
      sel = `SEL_RX_BUF;
    end
    accept = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
    wr_pend_nxt = accept && HWRITE_IN && hit;
    wr_sel_nxt = sel;
    wdata = HWDATA_IN[7:0];
    cfg_wr = wr_pend_r && (wr_sel_r == `SEL_CONFIG);
    ctl_wr = wr_pend_r && (wr_sel_r == `SEL_CONTROL);
    txb_wr = wr_pend_r && (wr_sel_r == `SEL_TX_BUF);
    // reads see the next values so a read right behind a write is not stale
    rdata_nxt = 32'h0000_0000;
    if (accept && !HWRITE_IN && hit) begin
      if (sel == `SEL_CONFIG) begin
        rdata_nxt[7:0] = {stop2_nxt, par_en_nxt, par_odd_nxt, clk_src_nxt, mode_nxt,
                          pin_en_nxt};
      end else if (sel == `SEL_CONTROL) begin
        rdata_nxt[7:0] = {msb_nxt, fer_nxt, per_nxt, oer_nxt, rx_trig_nxt, rx_en_nxt,
                          tx_trig_nxt, tx_en_nxt};
      end else if (sel == `SEL_TX_BUF) begin
        rdata_nxt[7:0] = tx_data_nxt;
      end else begin
        rdata_nxt[7:0] = rx_data_nxt;
      end
    end
  end

  // registers
  always_comb begin
    pin_en_nxt = pin_en_r;
    mode_nxt = mode_r;
    clk_src_nxt = clk_src_r;
    par_odd_nxt = par_odd_r;
    par_en_nxt = par_en_r;
    stop2_nxt = stop2_r;
    msb_nxt = msb_r;
    rx_en_nxt = rx_en_r;
    tx_en_nxt = tx_en_r;
    tx_data_nxt = tx_data_r;
    if (cfg_wr) begin
      stop2_nxt = wdata[`CFG_STOP2];
      par_en_nxt = wdata[`CFG_PAR_EN];
      par_odd_nxt = wdata[`CFG_PAR_ODD];
      clk_src_nxt = wdata[`CFG_CLK_HI:`CFG_CLK_LO];
      mode_nxt = wdata[`CFG_MODE_HI:`CFG_MODE_LO];
      pin_en_nxt = wdata[`CFG_PIN_EN];
    end
    if (ctl_wr) begin
      msb_nxt = wdata[`CTL_MSB_FIRST];
      rx_en_nxt = wdata[`CTL_RX_EN];
      tx_en_nxt = wdata[`CTL_TX_EN];
    end
    if (txb_wr) begin
      tx_data_nxt = wdata;
    end
    // a trigger while the engine still runs is dropped, status already reads one
    tx_go = ctl_wr && wdata[`CTL_TX_TRIG] && wdata[`CTL_TX_EN] && !tx_trig_r;
    rx_go = ctl_wr && wdata[`CTL_RX_TRIG] && wdata[`CTL_RX_EN] && !is_async && !rx_trig_r;
    tx_trig_nxt = tx_go || (tx_trig_r && !tx_done_r);
    // hardware clear loses against a software rearm in the same cycle
    rx_trig_nxt = rx_en_nxt && ((ctl_wr && wdata[`CTL_RX_TRIG]) || (rx_trig_r && !rx_done_r));
    fer_nxt = rx_en_nxt && (fer_ev_r || (fer_r && !(ctl_wr && wdata[`CTL_FER])));
    per_nxt = rx_en_nxt && (per_ev_r || (per_r && !(ctl_wr && wdata[`CTL_PER])));
    oer_nxt = rx_en_nxt && ((rx_done_r && is_async && !rx_trig_r)
              || (oer_r && !(ctl_wr && wdata[`CTL_OER])));
    rx_data_nxt = rx_done_r ? rx_shift_r : rx_data_r;
  end

  // transmit and receive engine
  always_comb begin
    is_async = mode_r[1];
    nbits = (mode_r == `MODE_ASYNC7) ? `BITS7 : `BITS8;
    sin_eff = pin_en_r ? SIN_IN : 1'b1;
    tx_adv = sc.tick && tx_half_r;
    rx_smp = sc.tick && !rx_half_r;
    tx_state_nxt = tx_state_r;
    rx_state_nxt = rx_state_r;
    tx_cnt_nxt = tx_cnt_r;
    rx_cnt_nxt = rx_cnt_r;
    tx_half_nxt = tx_half_r;
    rx_half_nxt = rx_half_r;
    tx_hold_nxt = tx_hold_r;
    rx_shift_nxt = rx_shift_r;
    sout_nxt = sout_r;
    sync_tx_nxt = sync_tx_r;
    sync_rx_nxt = sync_rx_r;
    rx_per_nxt = rx_per_r;
    tx_done_nxt = 1'b0;
    rx_done_nxt = 1'b0;
    fer_ev_nxt = 1'b0;
    per_ev_nxt = 1'b0;
    if (is_async && sc.tick && tx_state_r != serial_channel_pkg::TX_IDLE) begin
      tx_half_nxt = ~tx_half_r;
    end
    case (tx_state_r)
      serial_channel_pkg::TX_IDLE: begin
        if (!is_async && (tx_go || rx_go)) begin
          tx_state_nxt = serial_channel_pkg::TX_DATA;
          tx_cnt_nxt = 4'h0;
          tx_hold_nxt = tx_data_r;
          sync_tx_nxt = tx_go;
          sync_rx_nxt = rx_go;
          sout_nxt = tx_go ? tx_data_r[bit_pos(4'h0, `BITS8, msb_r)] : 1'b1;
        end else if (is_async) begin
          sout_nxt = 1'b1;
          if (tx_trig_r && !tx_done_r && sc.tick) begin
            tx_state_nxt = serial_channel_pkg::TX_START;
            tx_half_nxt = 1'b0;
            tx_hold_nxt = tx_data_r;
            sout_nxt = 1'b0;
          end
        end
      end
      serial_channel_pkg::TX_START: begin
        if (tx_adv) begin
          tx_state_nxt = serial_channel_pkg::TX_DATA;
          tx_cnt_nxt = 4'h0;
          sout_nxt = tx_hold_r[bit_pos(4'h0, nbits, msb_r)];
        end
      end
      serial_channel_pkg::TX_DATA: begin
        if (!is_async) begin
          if (sc.shift_ev) begin
            sout_nxt = sync_tx_r ? tx_hold_r[bit_pos(tx_cnt_r, `BITS8, msb_r)] : 1'b1;
          end
          if (sc.sample_ev) begin
            if (sync_rx_r) begin
              rx_shift_nxt[bit_pos(tx_cnt_r, `BITS8, msb_r)] = sin_eff;
            end
            if (tx_cnt_r == `BITS8 - 4'h1) begin
              tx_state_nxt = serial_channel_pkg::TX_IDLE;
              tx_done_nxt = sync_tx_r;
              rx_done_nxt = sync_rx_r;
            end else begin
              tx_cnt_nxt = tx_cnt_r + 4'h1;
            end
          end
        end else if (tx_adv) begin
          if (tx_cnt_r == nbits - 4'h1) begin
            tx_cnt_nxt = 4'h0;
            if (par_en_r) begin
              tx_state_nxt = serial_channel_pkg::TX_PARITY;
              sout_nxt = parity_bit(tx_hold_r, nbits, par_odd_r);
            end else begin
              tx_state_nxt = serial_channel_pkg::TX_STOP;
              sout_nxt = 1'b1;
            end
          end else begin
            tx_cnt_nxt = tx_cnt_r + 4'h1;
            sout_nxt = tx_hold_r[bit_pos(tx_cnt_r + 4'h1, nbits, msb_r)];
          end
        end
      end
      serial_channel_pkg::TX_PARITY: begin
        if (tx_adv) begin
          tx_state_nxt = serial_channel_pkg::TX_STOP;
          tx_cnt_nxt = 4'h0;
          sout_nxt = 1'b1;
        end
      end
      default: begin
        if (tx_adv) begin
          if (stop2_r && tx_cnt_r == 4'h0) begin
            tx_cnt_nxt = 4'h1;
          end else begin
            tx_state_nxt = serial_channel_pkg::TX_IDLE;
            tx_done_nxt = 1'b1;
          end
        end
      end
    endcase
    if (sc.tick && rx_state_r != serial_channel_pkg::RX_IDLE) begin
      rx_half_nxt = ~rx_half_r;
    end
    case (rx_state_r)
      serial_channel_pkg::RX_IDLE: begin
        if (!sin_eff) begin
          rx_state_nxt = serial_channel_pkg::RX_START;
          rx_half_nxt = 1'b0;
          rx_cnt_nxt = 4'h0;
        end
      end
      serial_channel_pkg::RX_START: begin
        if (rx_smp) begin
          // a start bit that is high again at mid bit was a glitch
          rx_state_nxt = sin_eff ? serial_channel_pkg::RX_IDLE : serial_channel_pkg::RX_DATA;
          rx_shift_nxt = 8'h00;
        end
      end
      serial_channel_pkg::RX_DATA: begin
        if (rx_smp) begin
          rx_shift_nxt[bit_pos(rx_cnt_r, nbits, msb_r)] = sin_eff;
          if (rx_cnt_r == nbits - 4'h1) begin
            rx_state_nxt = par_en_r ? serial_channel_pkg::RX_PARITY
                                    : serial_channel_pkg::RX_STOP;
            rx_per_nxt = 1'b0;
          end else begin
            rx_cnt_nxt = rx_cnt_r + 4'h1;
          end
        end
      end
      serial_channel_pkg::RX_PARITY: begin
        if (rx_smp) begin
          rx_per_nxt = (sin_eff != parity_bit(rx_shift_r, nbits, par_odd_r));
          rx_state_nxt = serial_channel_pkg::RX_STOP;
        end
      end
      default: begin
        if (rx_smp) begin
          rx_state_nxt = serial_channel_pkg::RX_IDLE;
          rx_done_nxt = 1'b1;
          fer_ev_nxt = !sin_eff;
          per_ev_nxt = rx_per_r;
        end
      end
    endcase
    // receiver only listens in async mode with reception enabled
    if (!is_async || !rx_en_r) begin
      rx_state_nxt = serial_channel_pkg::RX_IDLE;
    end
    srdy_nxt = !(mode_r == `MODE_SLAVE && tx_state_r == serial_channel_pkg::TX_DATA);
  end

  // pins: port function unless the channel owns them
  always_comb begin
    pins_nxt = pin_en_r;
    sout_pin_nxt = pin_en_r ? sout_r : 1'b1;
    sout_oe_nxt = pin_en_r;
    sclk_pin_nxt = sc.sclk;
    sclk_oe_nxt = pin_en_r && (mode_r != `MODE_SLAVE) && !is_async;
    srdy_pin_nxt = srdy_r;
    srdy_oe_nxt = pin_en_r && (mode_r == `MODE_SLAVE);
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      wr_pend_r <= 1'b0;
      wr_sel_r <= `SEL_CONFIG;
      rdata_r <= 32'h0000_0000;
      pin_en_r <= 1'b0;
      mode_r <= `MODE_MASTER;
      clk_src_r <= `CLK_DIV16;
      par_odd_r <= 1'b0;
      par_en_r <= 1'b0;
      stop2_r <= 1'b0;
      msb_r <= 1'b0;
      fer_r <= 1'b0;
      per_r <= 1'b0;
      oer_r <= 1'b0;
      rx_trig_r <= 1'b0;
      rx_en_r <= 1'b0;
      tx_trig_r <= 1'b0;
      tx_en_r <= 1'b0;
      tx_data_r <= 8'h00;
      rx_data_r <= 8'h00;
      tx_state_r <= serial_channel_pkg::TX_IDLE;
      rx_state_r <= serial_channel_pkg::RX_IDLE;
      tx_cnt_r <= 4'h0;
      rx_cnt_r <= 4'h0;
      tx_half_r <= 1'b0;
      rx_half_r <= 1'b0;
      tx_hold_r <= 8'h00;
      rx_shift_r <= 8'h00;
      sout_r <= 1'b1;
      srdy_r <= 1'b1;
      sync_tx_r <= 1'b0;
      sync_rx_r <= 1'b0;
      rx_per_r <= 1'b0;
      tx_done_r <= 1'b0;
      rx_done_r <= 1'b0;
      fer_ev_r <= 1'b0;
      per_ev_r <= 1'b0;
      sout_pin_r <= 1'b1;
      sout_oe_r <= 1'b0;
      sclk_pin_r <= 1'b1;
      sclk_oe_r <= 1'b0;
      srdy_pin_r <= 1'b1;
      srdy_oe_r <= 1'b0;
      pins_r <= 1'b0;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_sel_r <= wr_sel_nxt;
      rdata_r <= rdata_nxt;
      pin_en_r <= pin_en_nxt;
      mode_r <= mode_nxt;
      clk_src_r <= clk_src_nxt;
      par_odd_r <= par_odd_nxt;
      par_en_r <= par_en_nxt;
      stop2_r <= stop2_nxt;
      msb_r <= msb_nxt;
      fer_r <= fer_nxt;
      per_r <= per_nxt;
      oer_r <= oer_nxt;
      rx_trig_r <= rx_trig_nxt;
      rx_en_r <= rx_en_nxt;
      tx_trig_r <= tx_trig_nxt;
      tx_en_r <= tx_en_nxt;
      tx_data_r <= tx_data_nxt;
      rx_data_r <= rx_data_nxt;
      tx_state_r <= tx_state_nxt;
      rx_state_r <= rx_state_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      tx_half_r <= tx_half_nxt;
      rx_half_r <= rx_half_nxt;
      tx_hold_r <= tx_hold_nxt;
      rx_shift_r <= rx_shift_nxt;
      sout_r <= sout_nxt;
      srdy_r <= srdy_nxt;
      sync_tx_r <= sync_tx_nxt;
      sync_rx_r <= sync_rx_nxt;
      rx_per_r <= rx_per_nxt;
      tx_done_r <= tx_done_nxt;
      rx_done_r <= rx_done_nxt;
      fer_ev_r <= fer_ev_nxt;
      per_ev_r <= per_ev_nxt;
      sout_pin_r <= sout_pin_nxt;
      sout_oe_r <= sout_oe_nxt;
      sclk_pin_r <= sclk_pin_nxt;
      sclk_oe_r <= sclk_oe_nxt;
      srdy_pin_r <= srdy_pin_nxt;
      srdy_oe_r <= srdy_oe_nxt;
      pins_r <= pins_nxt;
    end
  end

  assign HRDATA_OUT = rdata_r;
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = 1'b0;
  assign SOUT_OUT = sout_pin_r;
  assign SOUT_OE_OUT = sout_oe_r;
  assign SCLK_OUT = sclk_pin_r;
  assign SCLK_OE_OUT = sclk_oe_r;
  assign SRDY_OUT = srdy_pin_r;
  assign SRDY_OE_OUT = srdy_oe_r;
  assign SERIAL_PINS_OUT = pins_r;
endmodule : serial_channel_control
`default_nettype wire

// file: verilog/serial_channel_defines.svh
// register offsets, field positions, codes and counts of the serial channel
// Function
// - mode field picks async 8/7-bit, slave, master
// - mode field reads back, resets to master
// - clock field picks timer, osc/4, /8, /16
// - timer source is programmable timer seven
// - slave mode shifts on external serial clock
// - clock field reads back, resets to /16
// - pin enable hands four pins to channel
// - pin enable reads back, resets to port
// - stop select gives two or one stops
// - parity enable adds and checks parity, async
// - parity select odd when set, even clear
// - bit order select msb or lsb first
// - error flags read one, write-one clears
// - receive trigger arms reception, reads run status
// - transmit buffer eight bits, read and write
// - receive buffer holds last received character
// - transmit trigger starts send, reads busy
// - overrun when character completes before rearm
// - framing error when stop bit reads zero
// - error flags held clear while receive disabled
`ifndef SERIAL_CHANNEL_DEFINES_SVH
`define SERIAL_CHANNEL_DEFINES_SVH

// register indices; byte address is four times the index
`define IDX_CONFIG 16'hFF4C
`define IDX_CONTROL 16'hFF4D
`define IDX_TX_BUF 16'hFF4E
`define IDX_RX_BUF 16'hFF4F
`define SEL_CONFIG 2'h0
`define SEL_CONTROL 2'h1
`define SEL_TX_BUF 2'h2
`define SEL_RX_BUF 2'h3

// configuration register fields
`define CFG_STOP2 7
`define CFG_PAR_EN 6
`define CFG_PAR_ODD 5
`define CFG_CLK_HI 4
`define CFG_CLK_LO 3
`define CFG_MODE_HI 2
`define CFG_MODE_LO 1
`define CFG_PIN_EN 0

// control and status register fields
`define CTL_MSB_FIRST 7
`define CTL_FER 6
`define CTL_PER 5
`define CTL_OER 4
`define CTL_RX_TRIG 3
`define CTL_RX_EN 2
`define CTL_TX_TRIG 1
`define CTL_TX_EN 0

// transfer modes
`define MODE_MASTER 2'h0
`define MODE_SLAVE 2'h1
`define MODE_ASYNC7 2'h2
`define MODE_ASYNC8 2'h3

// clock sources and divider ratios
`define CLK_TIMER 2'h3
`define CLK_DIV4 2'h2
`define CLK_DIV8 2'h1
`define CLK_DIV16 2'h0
`define RATIO_4 5'h04
`define RATIO_8 5'h08
`define RATIO_16 5'h10

// frame lengths
`define BITS7 4'h7
`define BITS8 4'h8
`define MASK7 8'h7F
`define MASK8 8'hFF

`endif

// file: verilog/serial_channel_pkg.sv
// state types of the serial channel
package serial_channel_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;
endpackage : serial_channel_pkg

// file: verilog/shift_clock_gen.sv
// shift clock generator: oscillator divider, timer tick, master and slave clock edges
`timescale 1ns/1ps
`default_nettype none
`include "serial_channel_defines.svh"
module shift_clock_gen (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // engine side
  shift_clock_if.gen sc
);
  logic [4:0] div_cnt_r, div_cnt_nxt;
  logic [4:0] ratio;
  logic base_tick;
  logic sclk_r, sclk_nxt;
  logic prev_r, prev_nxt;
  logic tick_r, tick_nxt;
  logic shift_r, shift_nxt;
  logic sample_r, sample_nxt;

  always_comb begin
    ratio = `RATIO_16;
    if (sc.clk_src == `CLK_DIV4) begin
      ratio = `RATIO_4;
    end else if (sc.clk_src == `CLK_DIV8) begin
      ratio = `RATIO_8;
    end
    // timer seven pulses stand in for the divider
    if (sc.clk_src == `CLK_TIMER) begin
      base_tick = sc.timer_tick;
    end else begin
      base_tick = (div_cnt_r == ratio - 5'h01);
    end
    div_cnt_nxt = (div_cnt_r == ratio - 5'h01) ? 5'h00 : div_cnt_r + 5'h01;
    tick_nxt = base_tick;
    prev_nxt = sc.ext_sclk;
    sclk_nxt = sclk_r;
    shift_nxt = 1'b0;
    sample_nxt = 1'b0;
    if (sc.mode == `MODE_SLAVE) begin
      // clock source is ignored: edges of the external clock only
      shift_nxt = prev_r & ~sc.ext_sclk;
      sample_nxt = ~prev_r & sc.ext_sclk;
      sclk_nxt = 1'b1;
    end else if (sc.mode == `MODE_MASTER) begin
      if (!sc.active) begin
        sclk_nxt = 1'b1;
      end else if (base_tick) begin
        sclk_nxt = ~sclk_r;
        shift_nxt = sclk_r;
        sample_nxt = ~sclk_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_cnt_r <= 5'h00;
      sclk_r <= 1'b1;
      prev_r <= 1'b1;
      tick_r <= 1'b0;
      shift_r <= 1'b0;
      sample_r <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      sclk_r <= sclk_nxt;
      prev_r <= prev_nxt;
      tick_r <= tick_nxt;
      shift_r <= shift_nxt;
      sample_r <= sample_nxt;
    end
  end

  assign sc.tick = tick_r;
  assign sc.shift_ev = shift_r;
  assign sc.sample_ev = sample_r;
  assign sc.sclk = sclk_r;
endmodule : shift_clock_gen
`default_nettype wire

// file: verilog/shift_clock_if.sv
// link between the channel engine and its shift clock generator
`timescale 1ns/1ps
`default_nettype none
interface shift_clock_if;
  logic [1:0] mode;
  logic [1:0] clk_src;
  logic active;
  logic timer_tick;
  logic ext_sclk;
  logic tick;
  logic shift_ev;
  logic sample_ev;
  logic sclk;
  modport gen (input mode, clk_src, active, timer_tick, ext_sclk,
               output tick, shift_ev, sample_ev, sclk);
  modport user (output mode, clk_src, active, timer_tick, ext_sclk,
                input tick, shift_ev, sample_ev, sclk);
endinterface : shift_clock_if
`default_nettype wire
